// ==== ussu_core.sv ====
// universal serial shift unit: shift register, bit counter, output latch,
// start/stop detection and two-wire clock hold.
// assumes cpu strobes arrive on sys_clk; pins are asynchronous and are
// synchronised here. open-drain style pins use output enables that are low
// while the unit drives the pin.
`timescale 1ns/1ps

module ussu_core (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire ussu_pkg::ussu_control_type control,
    input wire ussu_pkg::ussu_write_type cpu_write,
    input wire logic timer_match,
    input wire logic serial_data_input_pin,
    input wire logic serial_clock_pin,
    input wire logic port_clock_level,
    input wire logic port_clock_dir,
    input wire logic port_data_level,
    input wire logic data_dir,
    output logic [7:0] shift_data_register,
    output ussu_pkg::ussu_status_type serial_status_register,
    output logic data_out_pin,
    output logic data_out_oe_n,
    output logic sda_out,
    output logic sda_oe_n,
    output logic scl_out,
    output logic scl_oe_n,
    output logic start_irq,
    output logic overflow_irq
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection

    logic [1:0] pins_sync;
    logic data_in;
    logic clock_in;
    logic data_in_prev;
    logic clock_in_prev;
    logic clock_rise;
    logic clock_fall;
    logic [7:0] shift_reg;
    logic [3:0] count;
    logic out_latch;
    logic toggle_level;
    logic start_flag;
    logic overflow_flag;
    logic stop_flag;
    logic start_hold;
    logic two_wire;
    logic external_clock;
    logic shift_tick;
    logic count_tick;
    logic start_seen;
    logic stop_seen;
    logic wrap;
    logic latch_open;
    logic clock_pin_drive;
    logic [7:0] next_shift;
    logic [3:0] next_count;

    ussu_sync #(
        .width(2)
    ) pin_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in({serial_data_input_pin, serial_clock_pin}),
        .sync_out(pins_sync)
    );

    // RULE_03
    assign data_in = pins_sync[1];
    assign clock_in = pins_sync[0];

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            data_in_prev <= 1'b1;
            clock_in_prev <= 1'b1;
        end
        else
        begin
            data_in_prev <= data_in;
            clock_in_prev <= clock_in;
        end
    end

    assign clock_rise = clock_in && !clock_in_prev;
    assign clock_fall = !clock_in && clock_in_prev;

    ////////////////////////////////////////////////////////////////////////
    // clock source selection

    function automatic logic is_two_wire(
        input ussu_pkg::ussu_wire_mode_type mode
    );
        is_two_wire = (mode == ussu_pkg::ussu_wm_two) ||
            (mode == ussu_pkg::ussu_wm_two_hold);
    endfunction

    assign two_wire = is_two_wire(control.wire_mode);
    assign external_clock = control.clock_source[1];

    // RULE_05 RULE_10
    always_comb
    begin
        shift_tick = 1'b0;
        count_tick = 1'b0;
        case (control.clock_source)
            ussu_pkg::ussu_cs_soft:
            begin
                shift_tick = control.software_clock_strobe;
                count_tick = control.software_clock_strobe |
                    control.clock_toggle_strobe;
            end
            ussu_pkg::ussu_cs_timer:
            begin
                shift_tick = timer_match;
                count_tick = timer_match;
            end
            ussu_pkg::ussu_cs_ext_pos:
            begin
                // RULE_18
                shift_tick = clock_rise;
                // RULE_06
                count_tick = control.software_clock_strobe ?
                    control.clock_toggle_strobe : (clock_rise | clock_fall);
            end
            ussu_pkg::ussu_cs_ext_neg:
            begin
                // RULE_14
                shift_tick = clock_fall;
                count_tick = control.software_clock_strobe ?
                    control.clock_toggle_strobe : (clock_rise | clock_fall);
            end
            default:
            begin
                shift_tick = 1'b0;
                count_tick = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // shift register and counter

    // a write wins over a coincident serial clock
    always_comb
    begin
        next_shift = shift_reg;
        if (cpu_write.data_write)
        begin
            next_shift = cpu_write.data_value; // RULE_25
        end
        else if (shift_tick)
        begin
            next_shift = {shift_reg[6:0], data_in}; // RULE_09
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            shift_reg <= ussu_pkg::data_reset;
        end
        else
        begin
            shift_reg <= next_shift; // RULE_01
        end
    end

    assign wrap = count_tick && (count == ussu_pkg::count_max);

    always_comb
    begin
        next_count = count;
        if (cpu_write.count_write)
        begin
            // software loads 14 here to hold the clock after an ack
            next_count = cpu_write.count_value; // RULE_20
        end
        else if (count_tick)
        begin
            next_count = count + 4'h1; // RULE_04
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            count <= ussu_pkg::count_reset;
        end
        else
        begin
            count <= next_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output latch

    // open all the time with internal clocks; with an external clock it
    // opens only in the low half so output moves on the falling edge
    assign latch_open = !external_clock || !clock_in; // RULE_02

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            out_latch <= 1'b0;
        end
        else if (latch_open)
        begin
            out_latch <= next_shift[ussu_pkg::msb_pos]; // RULE_02
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // start and stop detection, flags

    // RULE_12 RULE_16
    assign start_seen = two_wire && clock_in && data_in_prev && !data_in;
    assign stop_seen = two_wire && clock_in && !data_in_prev && data_in;

    // set wins over a coincident clear on every flag
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            start_flag <= 1'b0;
        end
        else if (two_wire ? start_seen : count_tick)
        begin
            start_flag <= 1'b1; // RULE_07
        end
        else if (cpu_write.clear_start)
        begin
            start_flag <= 1'b0; // RULE_24
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            overflow_flag <= 1'b0;
        end
        else if (wrap && !cpu_write.count_write)
        begin
            overflow_flag <= 1'b1; // RULE_23
        end
        else if (cpu_write.clear_overflow)
        begin
            overflow_flag <= 1'b0; // RULE_23
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            stop_flag <= 1'b0;
        end
        else if (stop_seen)
        begin
            stop_flag <= 1'b1; // RULE_26
        end
        else if (cpu_write.clear_stop)
        begin
            stop_flag <= 1'b0; // RULE_26
        end
    end

    // hold starts on the first falling scl after start, not at the start
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            start_hold <= 1'b0;
        end
        else if (!start_flag || !two_wire)
        begin
            start_hold <= 1'b0; // RULE_24
        end
        else if (clock_fall)
        begin
            start_hold <= 1'b1; // RULE_17
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock toggle and pin drive

    // the toggle strobe flips an internal clock level like the port bit would
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            toggle_level <= 1'b1;
        end
        else if (control.clock_toggle_strobe)
        begin
            toggle_level <= !toggle_level; // RULE_10 RULE_11
        end
    end

    assign clock_pin_drive = port_clock_level ^ !toggle_level;

    // RULE_07 RULE_13 RULE_19: only two_wire_hold mode stretches on overflow
    always_comb
    begin
        scl_out = 1'b0;
        scl_oe_n = 1'b1;
        if (two_wire)
        begin
            if (start_hold ||
                (overflow_flag &&
                 control.wire_mode == ussu_pkg::ussu_wm_two_hold))
            begin
                scl_oe_n = 1'b0;
            end
            else if (port_clock_dir && !clock_pin_drive)
            begin
                scl_oe_n = 1'b0;
            end
        end
        else if (port_clock_dir)
        begin
            scl_out = clock_pin_drive;
            scl_oe_n = 1'b0;
        end
    end

    // RULE_08 RULE_21 RULE_22: direction bit decides who drives data
    always_comb
    begin
        data_out_pin = out_latch;
        data_out_oe_n = !(data_dir &&
            control.wire_mode == ussu_pkg::ussu_wm_three);
        sda_out = 1'b0;
        sda_oe_n = !(data_dir && two_wire &&
            (!out_latch || !port_data_level));
    end

    ////////////////////////////////////////////////////////////////////////
    // status and interrupt requests

    always_comb
    begin
        shift_data_register = shift_reg;
        serial_status_register.start_condition_flag = start_flag;
        serial_status_register.counter_overflow_flag = overflow_flag;
        serial_status_register.stop_condition_flag = stop_flag;
        serial_status_register.data_collision =
            two_wire && (shift_reg[ussu_pkg::msb_pos] != data_in);
        serial_status_register.count = count;
        start_irq = start_flag && control.start_irq_enable; // RULE_27
        overflow_irq = overflow_flag && control.overflow_irq_enable; // RULE_27
    end

endmodule

// ==== ussu_pkg.sv ====
// package for the universal serial shift unit: control encodings, reset
// values, counter constants and the packed carriers shared by its modules.
// assumes a single 200 MHz system clock domain; nothing else is needed.
//
// Overview of operation
// RULE_01 - eight-bit shift register, read and written directly, msb drives chosen pin
// RULE_02 - transparent output latch makes output change opposite to input sampling edge; with negative-edge clock, output changes on the sampling edge
// RULE_03 - serial input always sampled from data input pin in every wire mode
// RULE_04 - four-bit counter readable and writable, raises overflow request
// RULE_05 - register and counter clocked together from pin, timer match or software
// RULE_06 - external clock source: counter increments on both serial clock edges
// RULE_07 - two-wire: start detection flags and clock held low after start or overflow
// RULE_08 - three-wire works like spi modes zero and one, no slave select
// RULE_09 - two linked shift registers swap contents after eight clocks, overflow marks done
// RULE_10 - master clock made by toggling clock pin or writing toggle strobe
// RULE_11 - alternating toggle and software strobes give serial clock at quarter system rate
// RULE_12 - two-wire follows i2c on clock and data lines, no slew or filter
// RULE_13 - two-wire master clocks in software; only slave uses clock hold; shifting automatic
// RULE_14 - two-wire should shift on negative clock edge
// RULE_15 - master checks clock line really released after raising it
// RULE_16 - master signals start by pulling data low while clock high
// RULE_17 - start flag set; after next falling clock, clock held low until flag cleared
// RULE_18 - slave shifts data line in on each rising clock edge
// RULE_19 - after eight bits counter overflows and clock held low
// RULE_20 - addressed slave drives ack low; counter loaded with fourteen to hold after ack
// RULE_21 - read/write bit chooses which party enables its data output
// RULE_22 - further bytes keep direction until stop or repeated start
// RULE_23 - overflow flag set on fifteen to zero wrap, cleared by writing one
// RULE_24 - start flag cleared only by writing one, releasing start hold
// RULE_25 - serial clock in same cycle as data write: write kept, no shift
// RULE_26 - two-wire stop sets stop flag, cleared by writing one, no interrupt
// RULE_27 - start and overflow flags drive interrupt outputs, each gated by enable

package ussu_pkg;

    localparam int data_width = 8;
    localparam int count_width = 4;

    localparam logic [7:0] data_reset = 8'h00;
    localparam logic [3:0] count_reset = 4'h0;
    localparam logic [3:0] count_max = 4'hf;
    localparam logic [3:0] count_ack_load = 4'he;
    localparam int msb_pos = 7;

    // wire mode: high bit and wire_mode_select_low
    typedef enum logic [1:0] {
        ussu_wm_off = 2'h0,
        ussu_wm_three = 2'h1,
        ussu_wm_two = 2'h2,
        ussu_wm_two_hold = 2'h3
    } ussu_wire_mode_type;

    // clock source: clock_source_select_high, clock_source_select_low
    typedef enum logic [1:0] {
        ussu_cs_soft = 2'h0,
        ussu_cs_timer = 2'h1,
        ussu_cs_ext_pos = 2'h2,
        ussu_cs_ext_neg = 2'h3
    } ussu_clock_source_type;

    typedef struct packed {
        ussu_wire_mode_type wire_mode;
        ussu_clock_source_type clock_source;
        logic start_irq_enable;
        logic overflow_irq_enable;
        logic software_clock_strobe;
        logic clock_toggle_strobe;
    } ussu_control_type;

    typedef struct packed {
        logic start_condition_flag;
        logic counter_overflow_flag;
        logic stop_condition_flag;
        logic data_collision;
        logic [3:0] count;
    } ussu_status_type;

    // one-cycle write strobes with their data
    typedef struct packed {
        logic data_write;
        logic [7:0] data_value;
        logic count_write;
        logic [3:0] count_value;
        logic clear_start;
        logic clear_overflow;
        logic clear_stop;
    } ussu_write_type;

endpackage

// ==== ussu_sync.sv ====
// two-flop synchroniser for the pin inputs of the serial shift unit.
// assumes inputs are asynchronous to sys_clk; output is sys_clk aligned.
`timescale 1ns/1ps

module ussu_sync #(
    parameter int width = 3
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);

    logic [width-1:0] stage_one;

    // first stage feeds only the second; reset to idle-high line level
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            stage_one <= '1;
            sync_out <= '1;
        end
        else
        begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule

// ==== ussu_core_checker.sv ====
// concurrent checks on the serial shift unit core ports.
// assumes one sys_clk domain with synchronous active-low rst_n.
`timescale 1ns/1ps

module ussu_core_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire ussu_pkg::ussu_control_type control,
    input wire ussu_pkg::ussu_write_type cpu_write,
    input wire logic [7:0] shift_data_register,
    input wire ussu_pkg::ussu_status_type serial_status_register,
    input wire logic start_irq,
    input wire logic overflow_irq
);

    ussu_pkg::ussu_status_type st;
    assign st = serial_status_register;

    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    ovf_irq_gate_a: assert property (
        overflow_irq == (st.counter_overflow_flag &&
        control.overflow_irq_enable))
        else $error("overflow request not gated by its enable");
    start_irq_gate_a: assert property (
        start_irq == (st.start_condition_flag && control.start_irq_enable))
        else $error("start request not gated by its enable");
    ovf_flag_hold_a: assert property (
        st.counter_overflow_flag && !cpu_write.clear_overflow
        |=> st.counter_overflow_flag)
        else $error("overflow flag dropped without a clear");
    ovf_wrap_cause_a: assert property (
        $rose(st.counter_overflow_flag) |-> $past(st.count) == 4'hf &&
        !$past(cpu_write.count_write))
        else $error("overflow flag set without a wrap");
    start_flag_hold_a: assert property (
        st.start_condition_flag && !cpu_write.clear_start
        |=> st.start_condition_flag)
        else $error("start flag dropped without a clear");
    write_wins_a: assert property (
        cpu_write.data_write
        |=> shift_data_register == $past(cpu_write.data_value))
        else $error("written data not kept");
    count_load_a: assert property (
        cpu_write.count_write
        |=> st.count == $past(cpu_write.count_value))
        else $error("counter write not taken");
    soft_tick_a: assert property (
        control.software_clock_strobe && !cpu_write.count_write &&
        !cpu_write.data_write &&
        control.clock_source == ussu_pkg::ussu_cs_soft
        |=> st.count == $past(st.count) + 4'h1)
        else $error("software strobe did not count");

endmodule

bind ussu_core ussu_core_checker ussu_core_checker_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .control(control),
    .cpu_write(cpu_write),
    .shift_data_register(shift_data_register),
    .serial_status_register(serial_status_register),
    .start_irq(start_irq),
    .overflow_irq(overflow_irq)
);

// ==== ussu_far_master.sv ====
// far-side three-wire master: makes the serial clock, sends a byte msb
// first and captures the reply on each rising edge.
// assumes the unit samples on rising and changes output on falling edges.
`timescale 1ns/1ps

module ussu_far_master (
    input wire logic go,
    input wire logic [7:0] tx_byte,
    input wire logic miso,
    output logic sclk,
    output logic mosi,
    output logic [7:0] rx_byte,
    output logic busy
);

    // clock idles low between frames, mode zero
    initial
    begin
        sclk = 1'b0;
        mosi = 1'b0;
        busy = 1'b0;
        rx_byte = 8'h00;
    end

    always @(posedge go)
    begin
        busy = 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            mosi = tx_byte[i];
            #24 sclk = 1'b1;
            rx_byte = {rx_byte[6:0], miso};
            #24 sclk = 1'b0;
        end
        // released line: show the inverse, never a stale bit
        #12 mosi = ~mosi;
        busy = 1'b0;
    end

endmodule

// ==== ussu_core_tb.sv ====
// self-checking bench for the serial shift unit core with a far master.
// assumes the checker is bound in; results are matched through a queue.
`timescale 1ns/1ps

module ussu_core_tb;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    ussu_pkg::ussu_control_type control = '0;
    ussu_pkg::ussu_write_type cpu_write = '0;
    ussu_pkg::ussu_status_type st;
    logic timer_match = 1'b0;
    logic go = 1'b0;
    logic en = 1'b0;
    logic ovf_q = 1'b0;
    logic tw = 1'b0;
    logic tw_scl = 1'b1;
    logic tw_sda = 1'b1;
    logic pcd = 1'b0;
    logic do_oe_n, scl_out, scl_oe_n;
    logic sdi, sck, data_out_pin, start_irq, overflow_irq, busy;
    logic [7:0] shift_data_register, d, rx;
    logic [7:0] tx = 8'h00;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #2.5 sys_clk = ~sys_clk;

    ussu_core ussu_core_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .control(control),
        .cpu_write(cpu_write), .timer_match(timer_match),
        .serial_data_input_pin(tw ? tw_sda : sdi),
        .serial_clock_pin(tw ? tw_scl : sck),
        .port_clock_level(1'b0), .port_clock_dir(pcd),
        .port_data_level(1'b1), .data_dir(1'b1),
        .shift_data_register(shift_data_register),
        .serial_status_register(st), .data_out_pin(data_out_pin),
        .data_out_oe_n(do_oe_n), .sda_out(), .sda_oe_n(), .scl_out(scl_out),
        .scl_oe_n(scl_oe_n), .start_irq(start_irq), .overflow_irq(overflow_irq)
    );

    ussu_far_master ussu_far_master_i (
        .go(go), .tx_byte(tx), .miso(data_out_pin), .sclk(sck),
        .mosi(sdi), .rx_byte(rx), .busy(busy)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %0t byte %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_bit(input logic g, input logic e);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %0t flag %b expected %b", $time, g, e);
        end
    endtask

    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // clr is {start, overflow, stop}
    function automatic ussu_pkg::ussu_write_type mk(input logic [7:0] dv,
        input logic [3:0] cv, input logic [2:0] clr, input logic dw,
        input logic cw);
        mk = {dw, dv, cw, cv, clr};
    endfunction

    task automatic drive(input ussu_pkg::ussu_write_type w, input logic stb,
        input logic tm);
        @(posedge sys_clk);
        cpu_write <= w;
        control.software_clock_strobe <= stb;
        timer_match <= tm;
        @(posedge sys_clk);
        cpu_write <= '0;
        control.software_clock_strobe <= 1'b0;
        timer_match <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // completed bytes are matched against the oldest note
    always @(posedge sys_clk)
    begin
        ovf_q <= st.counter_overflow_flag;
        if (st.counter_overflow_flag === 1'b1 && ovf_q === 1'b0)
        begin
            if (exp_q.size() == 0)
                cmp_byte(shift_data_register, ~shift_data_register);
            else
                cmp_byte(shift_data_register, exp_q.pop_front());
        end
    end

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    initial
    begin
        void'($urandom(22));
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        cmp_byte(shift_data_register, ussu_pkg::data_reset);
        cmp_byte({st.start_condition_flag, st.counter_overflow_flag,
            st.stop_condition_flag, 1'b0, st.count}, 8'h00);
        control.wire_mode <= ussu_pkg::ussu_wm_three;
        control.overflow_irq_enable <= 1'b1;
        // software strobe then timer match, each wrapping the counter
        for (int s = 0; s < 2; s++)
        begin
            d = 8'($urandom);
            control.clock_source <= s ? ussu_pkg::ussu_cs_timer
                : ussu_pkg::ussu_cs_soft;
            drive(mk(d, 4'hf, 3'h0, 1'b1, 1'b1), 1'b0, 1'b0);
            exp_q.push_back({d[6:0], sdi});
            drive('0, s == 0, s == 1);
            @(posedge sys_clk);
            cmp_byte({4'h0, st.count}, 8'h00);
            cmp_bit(overflow_irq, 1'b1);
            drive(mk(8'h00, 4'h0, 3'h2, 1'b0, 1'b0), 1'b0, 1'b0);
            @(posedge sys_clk);
            cmp_bit(st.counter_overflow_flag, 1'b0);
        end
        // a strobe in the write cycle must not shift the new value
        d = 8'($urandom);
        control.clock_source <= ussu_pkg::ussu_cs_soft;
        drive(mk(d, 4'h0, 3'h0, 1'b1, 1'b0), 1'b1, 1'b0);
        @(posedge sys_clk);
        cmp_byte(shift_data_register, d);
        // toggle strobe alone: clock pin flips and the counter counts
        pcd <= 1'b1;
        @(posedge sys_clk);
        cmp_bit(scl_out, 1'b0);
        control.clock_toggle_strobe <= 1'b1;
        @(posedge sys_clk);
        control.clock_toggle_strobe <= 1'b0;
        @(posedge sys_clk);
        cmp_bit(scl_out, 1'b1);
        cmp_byte({4'h0, st.count}, 8'h02);
        en = 1'($urandom);
        control.clock_source <= ussu_pkg::ussu_cs_ext_pos;
        control.start_irq_enable <= en;
        repeat (3)
        begin
            d = 8'($urandom);
            tx = 8'($urandom);
            drive(mk(d, 4'h0, 3'h7, 1'b1, 1'b1), 1'b0, 1'b0);
            exp_q.push_back(tx);
            @(posedge sys_clk);
            go <= 1'b1;
            @(posedge sys_clk);
            go <= 1'b0;
            repeat (10) @(posedge sys_clk);
            while (busy === 1'b1)
                @(posedge sys_clk);
            repeat (8) @(posedge sys_clk);
            cmp_byte(rx, d);
            cmp_byte({4'h0, st.count}, 8'h00);
            cmp_bit(start_irq, en);
            cmp_bit(do_oe_n, 1'b0);
            drive(mk(8'h00, 4'h0, 3'h4, 1'b0, 1'b0), 1'b0, 1'b0);
            @(posedge sys_clk);
            cmp_bit(st.start_condition_flag, 1'b0);
        end
        // two-wire slave: start, clock hold, release, stop; the bench is
        // the master here. the pin switch may fake a stop, so flags are
        // cleared once the synchronisers have settled.
        control.wire_mode <= ussu_pkg::ussu_wm_two;
        control.clock_source <= ussu_pkg::ussu_cs_ext_neg;
        pcd <= 1'b0;
        tw <= 1'b1;
        repeat (6) @(posedge sys_clk);
        drive(mk(8'h00, 4'h0, 3'h7, 1'b0, 1'b1), 1'b0, 1'b0);
        tw_sda <= 1'b0;
        repeat (6) @(posedge sys_clk);
        cmp_bit(start_irq, en);
        cmp_bit(scl_oe_n, 1'b1);
        tw_scl <= 1'b0;
        repeat (6) @(posedge sys_clk);
        cmp_bit(scl_oe_n, 1'b0);
        drive(mk(8'h00, 4'h0, 3'h4, 1'b0, 1'b1), 1'b0, 1'b0);
        repeat (2) @(posedge sys_clk);
        cmp_bit(scl_oe_n, 1'b1);
        tw_scl <= 1'b1;
        repeat (6) @(posedge sys_clk);
        cmp_bit(scl_oe_n, 1'b1);
        tw_sda <= 1'b1;
        repeat (6) @(posedge sys_clk);
        cmp_bit(st.stop_condition_flag, 1'b1);
        cmp_byte(8'(exp_q.size()), 8'h00);
        summarize();
    end

endmodule
